// *** core/isc_consts.vh ***
// Constants of the serial control block: offsets, bit positions,
// reset values and timing counts. Definitions only.
`ifndef ISC_CONSTS_VH
`define ISC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISC_OFF_CTRL 8'h00
`define ISC_OFF_ADDR 8'h04
`define ISC_OFF_STAT 8'h08
`define ISC_OFF_RXD 8'h0C
`define ISC_OFF_TXD 8'h10

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define ISC_B_ON 15
`define ISC_B_IDLE 13
`define ISC_B_REL 12
`define ISC_B_STRICT 11
`define ISC_B_TEN 10
`define ISC_B_SLEW 9
`define ISC_B_SMB 8
`define ISC_B_GC 7
`define ISC_B_STR 6
`define ISC_B_ACKV 5

// ----------------------------------------------------------------
// Reset values, masks and counts
// ----------------------------------------------------------------
`define ISC_CTRL_RST 16'h1000
`define ISC_CFG_MASK 16'hAFE0
`define ISC_ADDR_RST 10'h000
`define ISC_TXD_RST 8'h00
`define ISC_QTR_CYC 125
`define ISC_FIFO_DEPTH 4
`define ISC_FIFO_AW 2

`endif

// *** core/isc_ctrl_one.v ***
// Two-wire serial controller behind control register one, APB slave.
// Assumes pull-ups on the lines and a pad that pulls low on enable.
//
// How it works
// - Module on: controller owns pins, else port
// - Module-on bit changed by software writes only
// - Idle-halt set: freeze engines in device idle
// - Reset or module off forces release to one
// - Stretch off: release zero drives clock low
// - Stretch on: written zero holds at low
// - Auto clear release: tx start, rx end
// - Strict: reserved addresses get a not-acknowledge, except general call and the own ten-bit header
// - Not strict: reserved addresses are acknowledged
// - Address width bit picks ten or seven
// - Command bits self-clear, reset to zero
`timescale 1ns/1ps
`include "isc_consts.vh"
module isc_ctrl_one #(
  parameter QTR_CYC = `ISC_QTR_CYC,
  parameter FIFO_DEPTH = `ISC_FIFO_DEPTH,
  parameter FIFO_AW = `ISC_FIFO_AW
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire idle_mode,
  input wire scl_i,
  input wire sda_i,
  output reg scl_o,
  output reg scl_oe,
  output reg sda_o,
  output reg sda_oe,
  output reg pins_owned,
  output reg slew_ctl_off,
  output reg smbus_levels_on
);
  localparam M_IDLE = 6'h01;
  localparam M_START = 6'h02;
  localparam M_RSTRT = 6'h04;
  localparam M_STOP = 6'h08;
  localparam M_RECV = 6'h10;
  localparam M_ACK = 6'h20;
  localparam S_IDLE = 8'h01;
  localparam S_ADDR = 8'h02;
  localparam S_ADR2 = 8'h04;
  localparam S_AACK = 8'h08;
  localparam S_TX = 8'h10;
  localparam S_RX = 8'h20;
  localparam S_RXEND = 8'h40;
  localparam S_DACK = 8'h80;

  reg [15:0] cfg_q;
  reg rel_q;
  reg [4:0] cmd_q;
  reg [9:0] own_q;
  reg [7:0] txd_q;
  wire module_on = cfg_q[`ISC_B_ON];
  wire run;
  wire [1:0] pins_s;
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  reg scl_p;
  reg sda_p;

  // ----------------------------------------------------------------
  // APB slave: one wait state, so every access takes three cycles
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire done = acc & pready;
  wire wr = done & pwrite & ~pslverr;
  wire wr_ctrl = wr & (paddr == `ISC_OFF_CTRL);
  wire fifo_ov;
  wire fifo_ir;
  wire [7:0] fifo_od;
  wire pop = done & ~pwrite & (paddr == `ISC_OFF_RXD) & fifo_ov;
  reg [31:0] rdata;
  reg hit;
  reg [5:0] m_state_q;
  reg [7:0] s_state_q;

  always @* begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `ISC_OFF_CTRL: rdata[15:0] = {cfg_q[15], 1'b0, cfg_q[13], rel_q,
                                    cfg_q[11:5], cmd_q};
      `ISC_OFF_ADDR: rdata[9:0] = own_q;
      `ISC_OFF_STAT: rdata[4:0] = {~fifo_ir, fifo_ov, s_state_q[4],
                                   |s_state_q[7:3], ~m_state_q[0]};
      `ISC_OFF_RXD: rdata[7:0] = fifo_od;
      `ISC_OFF_TXD: rdata[7:0] = txd_q;
      default: hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling and bus event detection
  // ----------------------------------------------------------------
  isc_sync #(.W(2)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(ce),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  assign run = module_on & ~(cfg_q[`ISC_B_IDLE] & idle_mode);
  wire s_rise = scl_s & ~scl_p;
  wire s_fall = ~scl_s & scl_p;
  wire s_start = scl_s & scl_p & sda_p & ~sda_s;
  wire s_stop = scl_s & scl_p & ~sda_p & sda_s;
  wire s_ev = run & ~s_start & ~s_stop;

  // ----------------------------------------------------------------
  // Slave address decode
  // ----------------------------------------------------------------
  reg [7:0] s_sh_q;
  reg [7:0] s_tsh_q;
  reg [3:0] s_cnt_q;
  reg s_rw_q;
  reg s_go2_q;
  reg s_tenok_q;
  reg s_acked_q;
  reg s_sda_low_q;
  reg hold_q;
  wire ten = cfg_q[`ISC_B_TEN];
  wire rsv = (s_sh_q[7:4] == 4'h0) | (s_sh_q[7:4] == 4'hF);
  wire hdr = (s_sh_q[7:1] == {5'b11110, own_q[9:8]});
  wire own7 = (s_sh_q[7:1] == own_q[6:0]);
  wire gc = cfg_q[`ISC_B_GC] & (s_sh_q == 8'h00);
  wire a_hit = gc
    | (ten ? hdr & (~s_sh_q[0] | s_tenok_q)
           : own7 & ~rsv)
    | (rsv & ~cfg_q[`ISC_B_STRICT]);
  wire s_push = s_ev & s_state_q[6] & fifo_ir;
  wire s_txb = s_ev & s_fall & ((s_state_q[3] & s_rw_q & ~s_go2_q)
    | (s_state_q[4] & (s_cnt_q == 4'h8) & s_acked_q));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wire m_fin;
  wire [4:0] m_clr = m_fin ? m_state_q[5:1] : 5'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `ISC_CTRL_RST & `ISC_CFG_MASK;
      rel_q <= 1'b1;
      cmd_q <= 5'h00;
      own_q <= `ISC_ADDR_RST;
      txd_q <= `ISC_TXD_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        cfg_q <= pwdata[15:0] & `ISC_CFG_MASK;
      end
      if (wr & (paddr == `ISC_OFF_ADDR)) begin
        own_q <= pwdata[9:0];
      end
      if (wr & (paddr == `ISC_OFF_TXD)) begin
        txd_q <= pwdata[7:0];
      end
      if (!module_on) begin
        rel_q <= 1'b1;
      end else if (wr_ctrl) begin
        rel_q <= pwdata[`ISC_B_REL];
      end else if (s_txb | s_push) begin
        rel_q <= 1'b0;
      end
      // A new command written in the finishing cycle is kept
      if (!module_on) begin
        cmd_q <= 5'h00;
      end else begin
        cmd_q <= (cmd_q & ~m_clr) | (wr_ctrl ? pwdata[4:0] : 5'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer, four quarter phases per bus clock
  // ----------------------------------------------------------------
  reg [15:0] q_cnt_q;
  reg [1:0] ph_q;
  reg [2:0] m_bit_q;
  reg [7:0] m_sh_q;
  reg m_scl_low_q;
  reg m_sda_low_q;
  wire tick = run & ~m_state_q[0] & (q_cnt_q == QTR_CYC[15:0] - 16'd1);
  assign m_fin = tick & (((m_state_q[1] | m_state_q[3]) & (ph_q == 2'd2))
    | ((m_state_q[2] | m_state_q[5]) & (ph_q == 2'd3))
    | (m_state_q[4] & (ph_q == 2'd3) & (m_bit_q == 3'd7)));
  wire m_push = m_fin & m_state_q[4];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state_q <= M_IDLE;
      q_cnt_q <= 16'd0;
      ph_q <= 2'd0;
      m_bit_q <= 3'd0;
      m_sh_q <= 8'h00;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
    end else if (ce) begin
      if (!module_on) begin
        m_state_q <= M_IDLE;
        m_scl_low_q <= 1'b0;
        m_sda_low_q <= 1'b0;
      end else if (run) begin
        q_cnt_q <= (m_state_q[0] | tick) ? 16'd0 : q_cnt_q + 16'd1;
        if (tick) begin
          ph_q <= ph_q + 2'd1;
        end
        if (m_fin) begin
          m_state_q <= M_IDLE;
        end
        case (m_state_q)
          M_IDLE: begin
            ph_q <= 2'd0;
            m_bit_q <= 3'd0;
            // Receive starts only with FIFO room; a slave push at its end still drops the byte
            if (cmd_q[0]) m_state_q <= M_START;
            else if (cmd_q[1]) m_state_q <= M_RSTRT;
            else if (cmd_q[2]) m_state_q <= M_STOP;
            else if (cmd_q[3] & fifo_ir) m_state_q <= M_RECV;
            else if (cmd_q[4]) m_state_q <= M_ACK;
          end
          M_START: if (tick) begin
            case (ph_q)
              2'd0: {m_scl_low_q, m_sda_low_q} <= 2'b00;
              2'd1: m_sda_low_q <= 1'b1;
              default: m_scl_low_q <= 1'b1;
            endcase
          end
          M_RSTRT: if (tick) begin
            case (ph_q)
              2'd0: m_sda_low_q <= 1'b0;
              2'd1: m_scl_low_q <= 1'b0;
              2'd2: m_sda_low_q <= 1'b1;
              default: m_scl_low_q <= 1'b1;
            endcase
          end
          M_STOP: if (tick) begin
            case (ph_q)
              2'd0: m_sda_low_q <= 1'b1;
              2'd1: m_scl_low_q <= 1'b0;
              default: m_sda_low_q <= 1'b0;
            endcase
          end
          M_RECV: if (tick) begin
            case (ph_q)
              2'd0: {m_scl_low_q, m_sda_low_q} <= 2'b10;
              2'd1: m_scl_low_q <= 1'b0;
              2'd2: m_sh_q <= {m_sh_q[6:0], sda_s};
              default: begin
                m_scl_low_q <= 1'b1;
                m_bit_q <= m_bit_q + 3'd1;
              end
            endcase
          end
          M_ACK: if (tick) begin
            case (ph_q)
              2'd0: begin
                m_scl_low_q <= 1'b1;
                m_sda_low_q <= ~cfg_q[`ISC_B_ACKV];
              end
              2'd1: m_scl_low_q <= 1'b0;
              2'd2: m_scl_low_q <= 1'b0;
              default: {m_scl_low_q, m_sda_low_q} <= 2'b10;
            endcase
          end
          default: m_state_q <= M_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave engine
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_state_q <= S_IDLE;
      s_sh_q <= 8'h00;
      s_tsh_q <= 8'h00;
      s_cnt_q <= 4'h0;
      s_rw_q <= 1'b0;
      s_go2_q <= 1'b0;
      s_tenok_q <= 1'b0;
      s_acked_q <= 1'b0;
      s_sda_low_q <= 1'b0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else if (ce) begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      if (!module_on) begin
        s_state_q <= S_IDLE;
        s_sda_low_q <= 1'b0;
        s_tenok_q <= 1'b0;
      end else if (run & s_stop) begin
        s_state_q <= S_IDLE;
        s_sda_low_q <= 1'b0;
        s_tenok_q <= 1'b0;
      end else if (run & s_start) begin
        s_state_q <= S_ADDR;
        s_cnt_q <= 4'h0;
        s_sda_low_q <= 1'b0;
      end else if (run) begin
        case (s_state_q)
          S_IDLE: s_cnt_q <= 4'h0;
          S_ADDR, S_ADR2, S_RX: begin
            if (s_rise) begin
              s_sh_q <= {s_sh_q[6:0], sda_s};
              s_cnt_q <= s_cnt_q + 4'h1;
            end else if (s_fall & (s_cnt_q == 4'h8)) begin
              s_state_q <= S_IDLE;
              if (s_state_q[5]) begin
                s_state_q <= S_RXEND;
              end else if (s_state_q[1] & a_hit) begin
                s_rw_q <= s_sh_q[0];
                s_go2_q <= ten & hdr & ~s_sh_q[0];
                s_sda_low_q <= 1'b1;
                s_state_q <= S_AACK;
              end else if (s_state_q[2] & (s_sh_q == own_q[7:0])) begin
                s_tenok_q <= 1'b1;
                s_go2_q <= 1'b0;
                s_sda_low_q <= 1'b1;
                s_state_q <= S_AACK;
              end
            end
          end
          S_AACK: if (s_fall) begin
            s_cnt_q <= 4'h0;
            s_sda_low_q <= 1'b0;
            if (s_go2_q) begin
              s_state_q <= S_ADR2;
            end else if (s_rw_q) begin
              s_state_q <= S_TX;
              s_tsh_q <= txd_q;
              s_sda_low_q <= ~txd_q[7];
            end else begin
              s_state_q <= S_RX;
            end
          end
          S_TX: begin
            // Software may refill the byte while the clock is held
            if ((s_cnt_q == 4'h0) & ~rel_q) begin
              s_tsh_q <= txd_q;
              s_sda_low_q <= ~txd_q[7];
            end
            if (s_rise & (s_cnt_q == 4'h8)) begin
              s_acked_q <= ~sda_s;
            end
            if (s_fall) begin
              s_cnt_q <= s_cnt_q + 4'h1;
              if (s_cnt_q < 4'h7) begin
                s_sda_low_q <= ~s_tsh_q[6];
                s_tsh_q <= {s_tsh_q[6:0], 1'b0};
              end else if (s_cnt_q == 4'h7) begin
                s_sda_low_q <= 1'b0;
              end else if (s_acked_q) begin
                s_cnt_q <= 4'h0;
                s_tsh_q <= txd_q;
                s_sda_low_q <= ~txd_q[7];
              end else begin
                s_state_q <= S_IDLE;
              end
            end
          end
          S_RXEND: if (s_push) begin
            s_sda_low_q <= 1'b1;
            s_state_q <= S_DACK;
          end
          S_DACK: if (s_fall) begin
            s_sda_low_q <= 1'b0;
            s_cnt_q <= 4'h0;
            s_state_q <= S_RX;
          end
          default: s_state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock stretch and pin drivers
  // ----------------------------------------------------------------
  wire s_sel = |s_state_q[7:3];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      pins_owned <= 1'b0;
      slew_ctl_off <= 1'b0;
      smbus_levels_on <= 1'b0;
    end else if (ce) begin
      if (rel_q | ~s_sel) begin
        hold_q <= 1'b0;
      end else if (~cfg_q[`ISC_B_STR]) begin
        hold_q <= 1'b1;
      end else if (~scl_s) begin
        hold_q <= 1'b1;
      end
      // Full FIFO also stretches, so the far master waits for room
      scl_oe <= module_on
        & (m_scl_low_q | hold_q | s_state_q[6]);
      sda_oe <= module_on & (m_sda_low_q | s_sda_low_q);
      pins_owned <= module_on;
      slew_ctl_off <= cfg_q[`ISC_B_SLEW];
      smbus_levels_on <= cfg_q[`ISC_B_SMB];
    end
  end

  // ----------------------------------------------------------------
  // Received byte buffer; slave has priority over master receive
  // ----------------------------------------------------------------
  isc_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .en(ce),
    .in_valid(s_push | m_push),
    .in_ready(fifo_ir),
    .in_data(s_push ? s_sh_q : m_sh_q),
    .out_valid(fifo_ov),
    .out_ready(pop),
    .out_data(fifo_od)
  );
endmodule // isc_ctrl_one

// *** core/isc_fifo.v ***
// Small first-word-fall-through FIFO with valid/ready on both sides.
// Assumes one clock; en low freezes all state.
`timescale 1ns/1ps
module isc_fifo #(
  parameter W = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_n,
  input wire en,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire [AW:0] used;
  wire do_wr;
  wire do_rd;

  assign used = wp_q - rp_q;
  assign in_ready = (used != DEPTH[AW:0]);
  assign out_valid = (used != {(AW+1){1'b0}});
  assign out_data = mem[rp_q[AW-1:0]];
  assign do_wr = en & in_valid & in_ready;
  assign do_rd = en & out_ready & out_valid;

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule // isc_fifo

// *** core/isc_sync.v ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs idle high, as pulled-up bus lines do.
`timescale 1ns/1ps
module isc_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rst_n,
  input wire en,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
    end else if (en) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule // isc_sync

// *** test/isc_bus_master.sv ***
// Behavioural far-side master on the two-wire bus, 160 ns bit time.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
module isc_bus_master (
  input wire scl,
  input wire sda,
  output reg scl_pull,
  output reg sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // High phase waits for the line, so slave stretching is honoured
  task clk_bit(input logic b, output logic r);
    sda_pull = !b;
    #40;
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #40;
    r = sda;
    #40;
    scl_pull = 1'b1;
    #40;
  endtask
  task start_cond;
    #80;
    sda_pull = 1'b1;
    #80;
    scl_pull = 1'b1;
    #40;
  endtask
  task send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task stop_cond;
    sda_pull = 1'b1;
    #40;
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #80;
    sda_pull = 1'b0;
    #80;
  endtask
endmodule // isc_bus_master

// *** test/isc_ctrl_one_asserts.sv ***
// Checker for the serial control block: APB timing and pin ownership.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/1ps
`include "isc_consts.vh"
module isc_ctrl_one_asserts (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe,
  input wire pins_owned
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_ctrl = ce && psel && penable && pready && pwrite &&
    paddr == `ISC_OFF_CTRL;
  reg on_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) on_q <= 1'b0;
    else if (wr_ctrl) on_q <= pwdata[`ISC_B_ON];
  end
  sequence setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence off_s;
    !pins_owned [*3];
  endsequence
  chk_one_wait: assert property (setup_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside completion");
  chk_ctrl_mapped: assert property (pready && paddr == 8'h00 |-> !pslverr)
    else $error("control register refused");
  chk_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  chk_on_follows: assert property (wr_ctrl |=> ##[0:1] pins_owned == on_q)
    else $error("pin ownership not following write");
  chk_on_sw_only: assert property ($changed(pins_owned) |->
    $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("module on changed without write");
  chk_off_quiet: assert property (off_s |-> !scl_oe && !sda_oe)
    else $error("line pulled while module off");
endmodule // isc_ctrl_one_asserts

bind isc_ctrl_one isc_ctrl_one_asserts chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .pins_owned(pins_owned));

// *** test/test_isc_ctrl_one.sv ***
// Bench for the serial control block: APB tasks and a far-side master.
// Assumes pull-ups on both lines; quarter phase cut to 4 cycles.
`timescale 1ns/1ps
`include "isc_consts.vh"
module test_isc_ctrl_one;
  localparam [31:0] ON = 32'h0000_8000;
  localparam [31:0] IDLE = 32'h0000_2000;
  localparam [31:0] REL = 32'h0000_1000;
  localparam [31:0] STRICT = 32'h0000_0800;
  localparam [31:0] TEN = 32'h0000_0400;
  reg pclk, presetn, psel, penable, pwrite, idle_mode;
  reg [7:0] paddr;
  reg [31:0] pwdata, r, m;
  reg e, a1, a2;
  wire [31:0] prdata;
  wire pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, pins_owned;
  wire slew_ctl_off, smbus_levels_on, m_scl, m_sda;
  wire scl = !(scl_oe || m_scl);
  wire sda = !(sda_oe || m_sda);
  integer fail_count, samples_checked, i;
  isc_ctrl_one #(.QTR_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .pins_owned(pins_owned), .slew_ctl_off(slew_ctl_off),
    .smbus_levels_on(smbus_levels_on));
  isc_bus_master pm (.scl(scl), .sda(sda), .scl_pull(m_scl),
    .sda_pull(m_sda));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input string what, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n = n + 1)
      @(posedge pclk);
    if (n == 20) check("pready", 32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls the control register until the masked bits reach val
  task wait_ctrl(input [31:0] mask, input [31:0] val);
    integer k;
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    for (k = 0; k < 300 && (r & mask) !== val; k = k + 1)
      apb(1'b0, `ISC_OFF_CTRL, 32'h0);
  endtask
  task probe(input [31:0] cfg, input [9:0] own, input [7:0] b, input x);
    apb(1'b1, `ISC_OFF_ADDR, {22'h0, own});
    apb(1'b1, `ISC_OFF_CTRL, ON | REL | cfg);
    pm.start_cond;
    pm.send_byte(b, a1);
    pm.stop_cond;
    check("address ack", {31'h0, a1}, {31'h0, x});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count = fail_count + 1;
    stop_test;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle_mode = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    check("ctrl reset", r, 32'h0000_1000);
    check("pins reset", {31'h0, pins_owned}, 32'h0);
    $display("test reset done");
    apb(1'b1, `ISC_OFF_CTRL, 32'h0000_FFE0);
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    check("ctrl config", r, 32'h0000_BFE0);
    check("pins on", {29'h0, pins_owned, slew_ctl_off, smbus_levels_on},
      32'h7);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, `ISC_OFF_CTRL, ON);
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    check("release written", r, ON);
    apb(1'b1, `ISC_OFF_CTRL, 32'h0);
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    check("ctrl off", r, 32'h0000_1000);
    $display("test config done");
    // Start, restart, receive, acknowledge, stop
    // Enable first: a command written with the enable is dropped
    apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT);
    for (i = 0; i < 5; i = i + 1) begin
      m = 32'h1 << ((i == 4) ? 2 : (i > 1) ? i + 1 : i);
      apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT | m);
      wait_ctrl(m, 32'h0);
      check("command clear", r & m, 32'h0);
    end
    apb(1'b0, `ISC_OFF_RXD, 32'h0);
    check("master rx", r, 32'h0000_00FF);
    $display("test commands done");
    idle_mode <= 1'b1;
    apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT | IDLE | 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b0, `ISC_OFF_CTRL, 32'h0);
    check("idle frozen", r & 32'h1, 32'h1);
    idle_mode <= 1'b0;
    wait_ctrl(32'h1, 32'h0);
    check("idle resumed", r & 32'h1, 32'h0);
    apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT | 32'h4);
    wait_ctrl(32'h4, 32'h0);
    $display("test idle done");
    probe(STRICT, 10'h03A, 8'h04, 1'b0);
    probe(32'h0, 10'h03A, 8'h04, 1'b1);
    probe(STRICT | TEN, 10'h2A5, 8'hF4, 1'b1);
    probe(STRICT, 10'h03A, 8'hF4, 1'b0);
    $display("test addressing done");
    // Second pass with stretching on: hold starts at the next low
    for (i = 0; i < 2; i = i + 1) begin
    apb(1'b1, `ISC_OFF_ADDR, 32'h0000_003A);
    apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT | (i ? 32'h40 : 32'h0));
    fork
      begin
        pm.start_cond;
        pm.send_byte(8'h74, a1);
        pm.send_byte(8'h5A, a2);
        pm.stop_cond;
      end
      begin
        wait_ctrl(REL, 32'h0);
        check("release cleared", r & REL, 32'h0);
        repeat (40) @(posedge pclk);
        check("clock held", {31'h0, scl}, 32'h0);
        apb(1'b0, `ISC_OFF_RXD, 32'h0);
        check("slave rx", r, 32'h0000_005A);
        apb(1'b1, `ISC_OFF_CTRL, ON | REL | STRICT | (i ? 32'h40 : 32'h0));
      end
    join
    check("slave acks", {30'h0, a1, a2}, 32'h3);
    end
    $display("test slave write done");
    stop_test;
  end
endmodule // test_isc_ctrl_one
